/* File: rtl/dcs_crc.sv */
// The implementer's own choices: the strobed register port and the placing of the registers.
`include "dcs_consts.svh"

// Summary of operation
// - writing the checksum value register loads it as the new generator seed
// - reading the checksum value register returns the running checksum, no side effect
// - in shift register mode, bits above the polynomial length always read back as zero
// - control bit 15 selects ip header mode when set, shift register mode when clear
// - in ip header mode only low 16 bits hold checksum, high bits read zero
// - in ip header mode writes are converted and reads are ones' complement
// - feedback mask bit set enables xor at that stage; ignored in ip mode
module dcs_crc #(
    parameter int unsigned AW = 8
) (
    input  wire logic          clock_i,
    input  wire logic          rst_n_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [31:0]   wdata_i,
    input  wire logic          wr_i,
    input  wire logic          rd_i,
    output logic      [31:0]   rdata_o,
    input  wire logic          feed_valid_i,
    input  wire logic [31:0]   feed_data_i
);

    dcs_pkg::dcs_mode_t mode_reg;
    logic [4:0]         polynomial_length_reg;
    logic [31:0]        mask_reg;
    logic [31:0]        state_reg;
    logic [31:0]        state_next;
    logic [31:0]        len_mask;
    logic [31:0]        view_data;
    logic [31:0]        read_next;
    logic               hit_ctrl;
    logic               hit_data;
    logic               hit_mask;

    // one bit per stage, msb of the fed word first
    function automatic logic [31:0] lfsr_step(
        input logic [31:0] crc_in,
        input logic [31:0] din,
        input logic [31:0] taps,
        input logic [31:0] lmask,
        input logic [4:0]  top
    );
        logic [31:0] crc;
        logic        fb;
        crc = crc_in & lmask;
        fb  = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            fb  = crc[top] ^ din[i];
            crc = ((crc << 1) ^ (fb ? taps : 32'h0000_0000)) & lmask;
        end
        return crc;
    endfunction

    // 16-bit ones' complement add with end-around carry
    function automatic logic [15:0] ip_add(
        input logic [15:0] acc,
        input logic [15:0] din
    );
        logic [16:0] sum;
        sum = {1'b0, acc} + {1'b0, din};
        return sum[15:0] + {15'h0000, sum[16]};
    endfunction

    // address decode, full compare so aliases read as zero
    assign hit_ctrl = (addr_i == AW'(`DCS_OFS_CTRL));
    assign hit_data = (addr_i == AW'(`DCS_OFS_DATA));
    assign hit_mask = (addr_i == AW'(`DCS_OFS_MASK));

    // length mask
    // a length of n keeps n+1 stages, so a zero length still leaves one live bit
    assign len_mask = 32'hffff_ffff >> (5'h1f - polynomial_length_reg);

    // software view of the running checksum
    always_comb begin
        if (mode_reg == dcs_pkg::dcs_mode_ip) begin
            view_data = {16'h0000, ~state_reg[15:0]};
        end else begin
            view_data = state_reg & len_mask;
        end
    end

    // control register: mode select and polynomial length
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_reg <= dcs_pkg::dcs_mode_lfsr;
            polynomial_length_reg <= `DCS_RST_POLYNOMIAL_LENGTH;
        end else if (wr_i && hit_ctrl) begin
            mode_reg <= wdata_i[`DCS_TYPE_BIT] ? dcs_pkg::dcs_mode_ip
                                               : dcs_pkg::dcs_mode_lfsr;
            polynomial_length_reg <= wdata_i[`DCS_POLYNOMIAL_LENGTH_MSB:`DCS_POLYNOMIAL_LENGTH_LSB];
        end
    end

    // feedback tap mask register
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mask_reg <= `DCS_RST_WORD;
        end else if (wr_i && hit_mask) begin
            mask_reg <= wdata_i;
        end
    end

    // next generator state; a seed write overrides a feed in the same cycle
    always_comb begin
        state_next = state_reg;
        if (wr_i && hit_data) begin
            if (mode_reg == dcs_pkg::dcs_mode_ip) begin
                state_next = {16'h0000, ~wdata_i[15:0]};
            end else begin
                state_next = wdata_i;
            end
        end else if (feed_valid_i) begin
            if (mode_reg == dcs_pkg::dcs_mode_ip) begin
                state_next = {16'h0000, ip_add(state_reg[15:0], feed_data_i[15:0])};
            end else begin
                state_next = lfsr_step(state_reg, feed_data_i, mask_reg,
                                       len_mask, polynomial_length_reg);
            end
        end
    end

    // generator state; reads never touch it
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= `DCS_RST_WORD;
        end else begin
            state_reg <= state_next;
        end
    end

    // read mux; unmapped offsets answer zero
    always_comb begin
        read_next = 32'h0000_0000;
        if (rd_i) begin
            if (hit_ctrl) begin
                read_next[`DCS_TYPE_BIT] = (mode_reg == dcs_pkg::dcs_mode_ip);
                read_next[`DCS_POLYNOMIAL_LENGTH_MSB:`DCS_POLYNOMIAL_LENGTH_LSB] = polynomial_length_reg;
            end else if (hit_data) begin
                read_next = view_data;
            end else if (hit_mask) begin
                read_next = mask_reg;
            end
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= `DCS_RST_WORD;
        end else begin
            rdata_o <= read_next;
        end
    end

    default clocking dcs_cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    // helper: ip mode flag for readability in properties
    logic ip_mode;
    assign ip_mode = (mode_reg == dcs_pkg::dcs_mode_ip);

    sequence lfsr_seed_s;
        wr_i && hit_data && !ip_mode;
    endsequence

    sequence ip_seed_s;
        wr_i && hit_data && ip_mode && !(hit_ctrl);
    endsequence

    sequence quiet_read_s;
        rd_i && hit_data && !feed_valid_i;
    endsequence

    seed_load_a: assert property (
        lfsr_seed_s ##1 (rd_i && hit_data && !feed_valid_i && !ip_mode)
        |=> rdata_o == ($past(wdata_i, 2) & $past(len_mask)))
        else $error("seed write not read back");

    read_value_a: assert property (
        rd_i && hit_data |=> rdata_o == $past(view_data))
        else $error("data read returned wrong value");

    read_quiet_a: assert property (
        quiet_read_s |=> $stable(state_reg))
        else $error("read disturbed the checksum");

    high_zero_a: assert property (
        rd_i && hit_data && !ip_mode |=> (rdata_o & ~$past(len_mask)) == 32'h0000_0000)
        else $error("bits above length not zero");

    type_bit_a: assert property (
        wr_i && hit_ctrl |=> ip_mode == $past(wdata_i[`DCS_TYPE_BIT]))
        else $error("mode select mismatch");

    ip_upper_a: assert property (
        rd_i && hit_data && ip_mode |=> rdata_o[31:16] == 16'h0000)
        else $error("ip mode upper half not zero");

    // converted write reads back as written
    ip_conv_a: assert property (
        ip_seed_s ##1 (quiet_read_s and ip_mode)
        |=> rdata_o[15:0] == $past(wdata_i[15:0], 2))
        else $error("ip seed not returned in complement form");

    ip_mask_a: assert property (
        feed_valid_i && ip_mode && !wr_i
        |=> ({16'h0000, state_reg[15:0]} % 32'h0000_ffff) ==
            (({16'h0000, $past(state_reg[15:0])} + {16'h0000, $past(feed_data_i[15:0])})
             % 32'h0000_ffff))
        else $error("ip feed wrong sum");

    // zero taps act as a plain shift
    lfsr_shift_a: assert property (
        feed_valid_i && !ip_mode && !wr_i && mask_reg == 32'h0000_0000
        |=> state_reg == 32'h0000_0000)
        else $error("shift without taps not zero");

    lfsr_write_a: assert property (
        wr_i && hit_data && !ip_mode |=> state_reg == $past(wdata_i))
        else $error("seed write did not load the generator");

    ip_write_a: assert property (
        wr_i && hit_data && ip_mode |=> state_reg == {16'h0000, ~$past(wdata_i[15:0])})
        else $error("ip seed not converted on write");

    ip_read_a: assert property (
        rd_i && hit_data && ip_mode |=> rdata_o[15:0] == ~$past(state_reg[15:0]))
        else $error("ip read not in complement form");

    state_hold_a: assert property (
        !wr_i && !feed_valid_i |=> $stable(state_reg))
        else $error("checksum moved without a write or feed");

    rdata_idle_a: assert property (
        !rd_i |=> rdata_o == 32'h0000_0000)
        else $error("read data stood past its cycle");

    unmapped_read_a: assert property (
        rd_i && !hit_ctrl && !hit_data && !hit_mask |=> rdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    // length mask covers stages up to the length
    len_mask_a: assert property (
        len_mask[polynomial_length_reg] && (&(len_mask | (32'hffff_ffff << polynomial_length_reg)))
        && (polynomial_length_reg == 5'h1f || !len_mask[polynomial_length_reg + 5'h01]))
        else $error("length mask misplaced");

    len_write_a: assert property (
        wr_i && hit_ctrl |=> polynomial_length_reg == $past(wdata_i[`DCS_POLYNOMIAL_LENGTH_MSB:`DCS_POLYNOMIAL_LENGTH_LSB]))
        else $error("polynomial length not loaded");

    lfsr_upper_a: assert property (
        feed_valid_i && !wr_i && !ip_mode
        |=> (state_reg & ~$past(len_mask)) == 32'h0000_0000)
        else $error("feed set bits above length");

    // mode moves only on a control write
    mode_hold_a: assert property (
        !(wr_i && hit_ctrl) |=> $stable(mode_reg))
        else $error("mode changed without a control write");

    ctrl_read_a: assert property (
        rd_i && hit_ctrl |=> rdata_o[`DCS_TYPE_BIT] == $past(ip_mode))
        else $error("type select not read back");

    // ip feed keeps upper half clear
    ip_feed_upper_a: assert property (
        feed_valid_i && !wr_i && ip_mode |=> state_reg[31:16] == 16'h0000)
        else $error("ip feed set upper half");

    mask_write_a: assert property (
        wr_i && hit_mask |=> mask_reg == $past(wdata_i))
        else $error("tap mask not loaded");

    mask_read_a: assert property (
        rd_i && hit_mask |=> rdata_o == $past(mask_reg))
        else $error("tap mask read wrong");

endmodule // dcs_crc

/* File: rtl/dcs_consts.svh */
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH

// register byte offsets
`define DCS_OFS_CTRL   8'h00
`define DCS_OFS_DATA   8'h04
`define DCS_OFS_MASK   8'h08

// control register field positions
`define DCS_TYPE_BIT   15
`define DCS_POLYNOMIAL_LENGTH_LSB   0
`define DCS_POLYNOMIAL_LENGTH_MSB   4

// reset values
`define DCS_RST_WORD   32'h0000_0000
`define DCS_RST_POLYNOMIAL_LENGTH   5'h00

`endif

/* File: rtl/dcs_pkg.sv */
package dcs_pkg;
    // checksum engine operating mode, chosen by the type select bit
    typedef enum logic {
        dcs_mode_lfsr,
        dcs_mode_ip
    } dcs_mode_t;
endpackage

/* File: test/dma_crc_seed_and_result_tb_top.sv */
module dma_crc_seed_and_result_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i, rst_n_i, wr_i, rd_i, feed_valid_i, pend;
    logic [7:0]  addr_i;
    logic [31:0] wdata_i, rdata_o, feed_data_i, exp_v, seed_v, mask_v, w, st;
    logic [16:0] ck;
    logic [31:0] exp_q[$];
    int          error_cnt, num_checks, seed;

    dcs_crc #(.AW(8)) uut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .feed_valid_i(feed_valid_i), .feed_data_i(feed_data_i));

    // free-running 40 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    // reference shift register, msb of the word first, taps gated by mask
    function automatic logic [31:0] step(logic [31:0] s, logic [31:0] d,
                                         logic [31:0] m, logic [4:0] l);
        logic [31:0] lm;
        lm = 32'hffff_ffff >> (5'h1f - l);
        for (int i = 31; i >= 0; i--) s = ((s << 1) ^ ((s[l] ^ d[i]) ? m : 32'h0)) & lm;
        return s;
    endfunction

    // wr, rd and feed each set all strobes and own one cycle, so calls follow back to back
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i       <= a;
        wdata_i      <= d;
        wr_i         <= 1'b1;
        rd_i         <= 1'b0;
        feed_valid_i <= 1'b0;
        @(posedge clock_i);
    endtask

    // the expectation is queued before the strobe so the monitor always finds it
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        addr_i       <= a;
        wr_i         <= 1'b0;
        rd_i         <= 1'b1;
        feed_valid_i <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic feed(input logic [31:0] d);
        feed_data_i  <= d;
        wr_i         <= 1'b0;
        rd_i         <= 1'b0;
        feed_valid_i <= 1'b1;
        @(posedge clock_i);
    endtask

    task automatic idle(input int n);
        wr_i         <= 1'b0;
        rd_i         <= 1'b0;
        feed_valid_i <= 1'b0;
        repeat (n) @(posedge clock_i);
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // read data stands only in the cycle after the strobe, so sample mid-cycle
    always @(posedge clock_i) pend <= rd_i;
    always @(negedge clock_i) begin
        if (pend) begin
            exp_v = exp_q.pop_front();
            num_checks++;
            if (rdata_o !== exp_v) begin
                error_cnt++;
                $display("wrong value rdata_o exp %h got %h", exp_v, rdata_o);
            end
        end
    end

    // whole sequence needs well under 200 cycles
    initial begin
        #(3000 * 25);
        error_cnt++;
        final_report;
    end

    initial begin
        seed = 47511;
        {rst_n_i, wr_i, rd_i, feed_valid_i} = 4'h0;
        addr_i = 8'h00;
        wdata_i = 32'h0;
        feed_data_i = 32'h0;
        repeat (20) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        seed_v = $random(seed);
        mask_v = $random(seed);
        w = $random(seed);
        wr(8'h00, 32'h0000_001f);
        rd(8'h00, 32'h0000_001f);
        wr(8'h08, mask_v);
        rd(8'h08, mask_v);
        wr(8'h04, seed_v);
        rd(8'h04, seed_v);
        rd(8'h04, seed_v);
        st = step(seed_v, w, mask_v, 5'h1f);
        feed(w);
        rd(8'h04, st);
        // short length hides the upper bits
        wr(8'h00, 32'h0000_0007);
        wr(8'h04, 32'hffff_ffff);
        rd(8'h04, 32'h0000_00ff);
        w = $random(seed);
        st = step(32'hffff_ffff, w, mask_v, 5'h07);
        feed(w);
        rd(8'h04, st);
        // with no taps set a whole word shifts the register empty
        wr(8'h08, 32'h0000_0000);
        feed(w);
        rd(8'h04, 32'h0000_0000);
        wr(8'h08, mask_v);
        // ip header mode reads back the written low half; taps stay set to show they are unused
        wr(8'h00, 32'h0000_8000);
        rd(8'h00, 32'h0000_8000);
        wr(8'h04, seed_v);
        rd(8'h04, {16'h0, seed_v[15:0]});
        rd(8'h04, {16'h0, seed_v[15:0]});
        w = $random(seed);
        ck = {1'b0, ~seed_v[15:0]} + {1'b0, w[15:0]};
        feed(w);
        rd(8'h04, {16'h0000, ~(ck[15:0] + {15'h0000, ck[16]})});
        rd(8'h0c, 32'h0);
        // a reset in mid-run clears mode, length and checksum
        idle(1);
        rst_n_i <= 1'b0;
        idle(2);
        rst_n_i <= 1'b1;
        rd(8'h04, 32'h0);
        rd(8'h00, 32'h0);
        idle(4);
        final_report;
    end
endmodule // dma_crc_seed_and_result_tb_top
